// *** hdl/acrc_pkg.sv ***
package acrc_pkg;

    // register offsets as printed (not all multiples of four): indices, byte address = 4 * index
    localparam logic [7:0] IDX_INTERNAL_CLOCK_CFG = 8'h0d; // internal clock divider register
    localparam logic [7:0] IDX_MOD_CLOCK_AND_RATE = 8'h0e; // modulator divider and oversampling
    localparam logic [7:0] IDX_CHANNEL_POWER_ENABLE = 8'h0f; // global channel power
    localparam logic [7:0] IDX_RESERVED_FUTURE = 8'h10; // reserved for future use

    // reset values
    localparam logic [7:0] RST_INTERNAL_CLOCK_CFG = 8'h08;
    localparam logic [7:0] RST_MOD_CLOCK_AND_RATE = 8'h86;
    localparam logic [7:0] RST_CHANNEL_POWER_ENABLE = 8'h00;
    localparam logic [7:0] RST_RESERVED_FUTURE = 8'h00;

    // field positions
    localparam int MODULATOR_DIVIDER_SELECT_LSB = 1; // external clock divider select, bits 3:1
    localparam int MOD_DIV_LSB = 5; // modulator divider select, bits 7:5
    localparam int OSR_LSB = 0; // oversampling ratio select, bits 3:0
    localparam int PWR_LSB = 0; // channel power field, bits 3:0

    // channel power encodings
    localparam logic [3:0] PWR_ALL_DOWN = 4'h0;
    localparam logic [3:0] PWR_ALL_UP = 4'hf;

    // widths of the counters
    localparam int DIV_W = 4; // half-period counter for even dividers up to 14
    localparam int OSR_W = 12; // counter for ratios up to 4096

    // divider state machine
    typedef enum logic [1:0] {
        ACRC_DIV_IDLE = 2'b00,
        ACRC_DIV_RUN = 2'b01
    } acrc_div_state_type;

    // settings handed from the register file to the clock engine
    typedef struct packed {
        logic [2:0] internal_clock_sel; // internal clock divider code
        logic [2:0] mod_sel; // modulator divider code
        logic [3:0] osr_sel; // oversampling ratio code
        logic [3:0] pwr; // channel power field
    } acrc_cfg_type;

    // engine outputs
    typedef struct packed {
        logic internal_clock; // internal clock, as a level
        logic mod_clk; // modulator clock, as a level
        logic data_ready; // one-cycle pulse per output word period
        logic ch_on; // all channels powered up
    } acrc_clk_type;

    // oversampling ratio lookup
    function automatic logic [12:0] osr_ratio(input logic [3:0] code);
        logic [12:0] r;
        r = 13'h0;
        unique case (code)
            4'h0: r = 13'h1000;
            4'h1: r = 13'h0800;
            4'h2: r = 13'h0400;
            4'h3: r = 13'h0320;
            4'h4: r = 13'h0300;
            4'h5: r = 13'h0200;
            4'h6: r = 13'h0190;
            4'h7: r = 13'h0180;
            4'h8: r = 13'h0100;
            4'h9: r = 13'h00c8;
            4'ha: r = 13'h00c0;
            4'hb: r = 13'h0080;
            4'hc: r = 13'h0060;
            4'hd: r = 13'h0040;
            4'he: r = 13'h0030;
            4'hf: r = 13'h0020;
        endcase
        return r;
    endfunction

endpackage

// *** hdl/acrc_div_even.sv ***
`timescale 1ns/10ps
// even divider: toggles its output every sel input ticks, giving a period of 2*sel ticks
module acrc_div_even (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick_in, // one-cycle enable from the faster stage
    input wire logic [2:0] sel, // divide code, period = 2 * sel
    output logic clk_out, // divided level
    output logic tick_out // one-cycle pulse on each rising edge of clk_out
);
    logic [2:0] cnt_ff, nxt_cnt; // ticks seen in the current half period
    logic [2:0] sel_ff, nxt_sel; // ratio in force, only reloaded at a period boundary or while it holds the reserved code
    logic lvl_ff, nxt_lvl; // divided level
    logic tick_ff, nxt_tick; // rising-edge pulse

    // next values; a new code is taken only when a full period ends or while the reserved code holds the level low, so no short half period
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_sel = sel_ff;
        nxt_lvl = lvl_ff;
        nxt_tick = 1'b0;
        if (sel_ff == 3'h0) begin
            // reserved code: hold low and wait for a legal one
            nxt_lvl = 1'b0;
            nxt_sel = sel;
            nxt_cnt = 3'h0;
        end else if (tick_in) begin
            if (cnt_ff == sel_ff - 3'h1) begin
                nxt_cnt = 3'h0;
                nxt_lvl = ~lvl_ff;
                nxt_tick = ~lvl_ff;
                if (lvl_ff) begin
                    nxt_sel = sel;
                end
            end else begin
                nxt_cnt = cnt_ff + 3'h1;
            end
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 3'h0;
            sel_ff <= 3'h0;
            lvl_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            sel_ff <= nxt_sel;
            lvl_ff <= nxt_lvl;
            tick_ff <= nxt_tick;
        end
    end

    assign clk_out = lvl_ff;
    assign tick_out = tick_ff;

    // a legal ratio keeps the level for exactly sel ticks
    half_period_a: assert property (@(posedge clk) disable iff (rst)
        (sel_ff != 3'h0 && tick_in && cnt_ff == sel_ff - 3'h1) |=> (lvl_ff != $past(lvl_ff)))
        else $error("divider missed its toggle");
endmodule

// *** hdl/acrc_top.sv ***
`timescale 1ns/10ps
module acrc_top (
    input wire logic MCLK, // system clock, also the external input clock
    input wire logic RST, // synchronous, active high
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic INTERNAL_CLOCK, // internal clock level
    output logic MOD_CLOCK, // modulator clock level
    output logic DATA_READY, // one-cycle pulse per output word
    output logic [3:0] CHANNEL_POWER // per-channel power enables
);

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] internal_clock_reg_ff, nxt_internal_clock_reg; // internal clock configuration
    logic [7:0] mod_reg_ff, nxt_mod_reg; // modulator clock and rate
    logic [7:0] pwr_reg_ff, nxt_pwr_reg; // channel power enable
    logic [7:0] rsv_reg_ff, nxt_rsv_reg; // reserved register, kept as plain storage
    logic [31:0] rdata_ff, nxt_rdata; // read data holding
    logic err_ff, nxt_err; // slave error for unmapped addresses
    logic acc_ff, nxt_acc; // access-phase answer flag
    logic [5:0] idx; // word index from the byte address
    logic hit; // address decodes to a register
    acrc_pkg::acrc_cfg_type cfg; // settings to the clock engine

    // byte address to word index; the two low address bits are ignored
    assign idx = PADDR[7:2];

    // decode: only the four word addresses answer without error
    always_comb begin
        hit = (idx == acrc_pkg::IDX_INTERNAL_CLOCK_CFG[5:0]) || (idx == acrc_pkg::IDX_MOD_CLOCK_AND_RATE[5:0]) ||
              (idx == acrc_pkg::IDX_CHANNEL_POWER_ENABLE[5:0]) || (idx == acrc_pkg::IDX_RESERVED_FUTURE[5:0]);
    end

    // next register values; zero-wait-state slave, answered in the first access cycle
    always_comb begin
        nxt_internal_clock_reg = internal_clock_reg_ff;
        nxt_mod_reg = mod_reg_ff;
        nxt_pwr_reg = pwr_reg_ff;
        nxt_rsv_reg = rsv_reg_ff;
        nxt_rdata = rdata_ff;
        nxt_err = 1'b0;
        nxt_acc = 1'b0;
        if (PSEL && !PENABLE) begin
            // setup cycle: prepare the answer for the access phase
            nxt_acc = 1'b1;
            nxt_err = !hit;
            nxt_rdata = 32'h0;
            if (!PWRITE) begin
                // reserved bits read back what was stored; host keeps them zero
                unique case (1'b1)
                    idx == acrc_pkg::IDX_INTERNAL_CLOCK_CFG[5:0]: nxt_rdata = {24'h0, internal_clock_reg_ff};
                    idx == acrc_pkg::IDX_MOD_CLOCK_AND_RATE[5:0]: nxt_rdata = {24'h0, mod_reg_ff};
                    idx == acrc_pkg::IDX_CHANNEL_POWER_ENABLE[5:0]: nxt_rdata = {24'h0, pwr_reg_ff};
                    idx == acrc_pkg::IDX_RESERVED_FUTURE[5:0]: nxt_rdata = {24'h0, rsv_reg_ff};
                    default: nxt_rdata = 32'h0;
                endcase
            end
        end
        if (PSEL && PENABLE && acc_ff && PWRITE) begin
            // write takes effect at the edge where pready is sampled high
            if (idx == acrc_pkg::IDX_INTERNAL_CLOCK_CFG[5:0]) begin
                nxt_internal_clock_reg = PWDATA[7:0];
            end
            if (idx == acrc_pkg::IDX_MOD_CLOCK_AND_RATE[5:0]) begin
                nxt_mod_reg = PWDATA[7:0];
            end
            if (idx == acrc_pkg::IDX_CHANNEL_POWER_ENABLE[5:0]) begin
                nxt_pwr_reg = PWDATA[7:0];
            end
            if (idx == acrc_pkg::IDX_RESERVED_FUTURE[5:0]) begin
                nxt_rsv_reg = PWDATA[7:0];
            end
        end
    end

    // register stage
    always_ff @(posedge MCLK) begin
        if (RST) begin
            internal_clock_reg_ff <= acrc_pkg::RST_INTERNAL_CLOCK_CFG;
            mod_reg_ff <= acrc_pkg::RST_MOD_CLOCK_AND_RATE;
            pwr_reg_ff <= acrc_pkg::RST_CHANNEL_POWER_ENABLE;
            rsv_reg_ff <= acrc_pkg::RST_RESERVED_FUTURE;
            rdata_ff <= 32'h0;
            err_ff <= 1'b0;
            acc_ff <= 1'b0;
        end else begin
            internal_clock_reg_ff <= nxt_internal_clock_reg;
            mod_reg_ff <= nxt_mod_reg;
            pwr_reg_ff <= nxt_pwr_reg;
            rsv_reg_ff <= nxt_rsv_reg;
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
            acc_ff <= nxt_acc;
        end
    end

    // pready is combinational, so every transfer ends in its first access cycle
    assign PREADY = acc_ff && PSEL && PENABLE;
    assign PSLVERR = PREADY && err_ff;
    assign PRDATA = rdata_ff;

    // fields handed to the clock engine; reserved bits are stored but drive nothing
    assign cfg.internal_clock_sel = internal_clock_reg_ff[acrc_pkg::MODULATOR_DIVIDER_SELECT_LSB +: 3];
    assign cfg.mod_sel = mod_reg_ff[acrc_pkg::MOD_DIV_LSB +: 3];
    assign cfg.osr_sel = mod_reg_ff[acrc_pkg::OSR_LSB +: 4];
    assign cfg.pwr = pwr_reg_ff[acrc_pkg::PWR_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////////////
    // clock chain: external clock -> internal clock -> modulator clock -> data rate

    logic internal_clock_tick; // one pulse per internal clock period
    logic mod_tick; // one pulse per modulator clock period
    acrc_pkg::acrc_clk_type clk_out; // gathered engine outputs

    // the dividers run even while channels are powered down; only the word counter stops
    // internal clock from the external input clock, here MCLK itself
    acrc_div_even u_modulator_divider_select (
        .clk(MCLK),
        .rst(RST),
        .tick_in(1'b1),
        .sel(cfg.internal_clock_sel),
        .clk_out(clk_out.internal_clock),
        .tick_out(internal_clock_tick)
    );

    // modulator clock from the internal clock
    acrc_div_even u_mod_div (
        .clk(MCLK),
        .rst(RST),
        .tick_in(internal_clock_tick),
        .sel(cfg.mod_sel),
        .clk_out(clk_out.mod_clk),
        .tick_out(mod_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // oversampling counter

    logic [12:0] osr_cnt_ff, nxt_osr_cnt; // modulator periods into the current word
    logic [12:0] osr_ratio_ff, nxt_osr_ratio; // ratio in force for the current word
    logic drdy_ff, nxt_drdy; // data-ready pulse

    // a new ratio is loaded only when a word period completes or while powered down, so no word is cut short
    always_comb begin
        nxt_osr_cnt = osr_cnt_ff;
        nxt_osr_ratio = osr_ratio_ff;
        nxt_drdy = 1'b0;
        if (!clk_out.ch_on) begin
            // powered down: clear the count and pick up the ratio for the restart
            nxt_osr_cnt = 13'h0;
            nxt_osr_ratio = acrc_pkg::osr_ratio(cfg.osr_sel);
        end else if (mod_tick) begin
            if (osr_cnt_ff == osr_ratio_ff - 13'h1) begin
                nxt_osr_cnt = 13'h0;
                nxt_drdy = 1'b1;
                nxt_osr_ratio = acrc_pkg::osr_ratio(cfg.osr_sel);
            end else begin
                nxt_osr_cnt = osr_cnt_ff + 13'h1;
            end
        end
    end

    // register stage
    always_ff @(posedge MCLK) begin
        if (RST) begin
            osr_cnt_ff <= 13'h0;
            osr_ratio_ff <= 13'h0190;
            drdy_ff <= 1'b0;
        end else begin
            osr_cnt_ff <= nxt_osr_cnt;
            osr_ratio_ff <= nxt_osr_ratio;
            drdy_ff <= nxt_drdy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel power

    logic [3:0] pwr_ff, nxt_pwr; // registered channel enables

    // only the all-up code powers channels; any illegal pattern is treated as all-down
    always_comb begin
        nxt_pwr = (cfg.pwr == acrc_pkg::PWR_ALL_UP) ? 4'hf : 4'h0;
    end

    // register stage
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pwr_ff <= 4'h0;
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end

    assign clk_out.ch_on = (pwr_ff == 4'hf);
    assign clk_out.data_ready = drdy_ff;

    // each clock and power output comes straight from a flip-flop
    assign INTERNAL_CLOCK = clk_out.internal_clock;
    assign MOD_CLOCK = clk_out.mod_clk;
    assign DATA_READY = clk_out.data_ready;
    assign CHANNEL_POWER = pwr_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    // all of them sample on the system clock and sleep through reset

    // channel enables are always all-on or all-off
    power_global_a: assert property (@(posedge MCLK) disable iff (RST)
        (CHANNEL_POWER == 4'h0) || (CHANNEL_POWER == 4'hf))
        else $error("channel power not global");

    // an all-on write powers the channels two edges later
    power_on_a: assert property (@(posedge MCLK) disable iff (RST)
        (PREADY && PWRITE && idx == acrc_pkg::IDX_CHANNEL_POWER_ENABLE[5:0] && PWDATA[3:0] == 4'hf)
        |=> ##1 (CHANNEL_POWER == 4'hf))
        else $error("channels did not power up");

    // an all-off write powers the channels down two edges later
    power_off_a: assert property (@(posedge MCLK) disable iff (RST)
        (PREADY && PWRITE && idx == acrc_pkg::IDX_CHANNEL_POWER_ENABLE[5:0] && PWDATA[3:0] == 4'h0)
        |=> ##1 (CHANNEL_POWER == 4'h0))
        else $error("channels did not power down");

    // data-ready only at word end, after the last modulator tick
    drdy_cause_a: assert property (@(posedge MCLK) disable iff (RST)
        DATA_READY |-> $past(mod_tick) && $past(osr_cnt_ff) == $past(osr_ratio_ff) - 13'h1)
        else $error("data ready without full word");

    // no data-ready pulse follows a powered-down cycle
    drdy_power_a: assert property (@(posedge MCLK) disable iff (RST)
        DATA_READY |-> $past(clk_out.ch_on))
        else $error("data ready while powered down");

    // at a word end the ratio of the current code is taken for the next word
    osr_load_a: assert property (@(posedge MCLK) disable iff (RST)
        (clk_out.ch_on && mod_tick && osr_cnt_ff == osr_ratio_ff - 13'h1)
        |=> osr_ratio_ff == acrc_pkg::osr_ratio($past(cfg.osr_sel)))
        else $error("ratio not reloaded at word end");

    // reset settings: the modulator tick period is 64 cycles, so at least 8 quiet edges follow one
    mod_default_a: assert property (@(posedge MCLK) disable iff (RST)
        (mod_tick && $stable(mod_reg_ff) && $stable(internal_clock_reg_ff) && mod_reg_ff == acrc_pkg::RST_MOD_CLOCK_AND_RATE
         && internal_clock_reg_ff == acrc_pkg::RST_INTERNAL_CLOCK_CFG) |=> !mod_tick [*8])
        else $error("modulator period too short");

    // the modulator level only moves on an internal clock tick
    mod_step_a: assert property (@(posedge MCLK) disable iff (RST)
        $changed(MOD_CLOCK) |-> $past(internal_clock_tick))
        else $error("modulator clock moved between ticks");

    // reserved register reads back its stored value
    rsv_read_a: assert property (@(posedge MCLK) disable iff (RST)
        (PREADY && !PWRITE && idx == acrc_pkg::IDX_RESERVED_FUTURE[5:0]) |-> PRDATA == {24'h0, rsv_reg_ff})
        else $error("reserved register readback");

    // write to the reserved register lands in storage
    rsv_write_a: assert property (@(posedge MCLK) disable iff (RST)
        (PREADY && PWRITE && idx == acrc_pkg::IDX_RESERVED_FUTURE[5:0]) |=> rsv_reg_ff == $past(PWDATA[7:0]))
        else $error("reserved register write lost");

    // answer comes in the first access cycle
    apb_ready_a: assert property (@(posedge MCLK) disable iff (RST)
        (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> PREADY)
        else $error("slave did not answer");

    // the ratio in force changes only at a word boundary or while powered down
    osr_hold_a: assert property (@(posedge MCLK) disable iff (RST)
        (clk_out.ch_on && !(mod_tick && osr_cnt_ff == osr_ratio_ff - 13'h1)) |=> $stable(osr_ratio_ff))
        else $error("ratio changed mid-word");

    // write to channel register lands in storage
    pwr_write_a: assert property (@(posedge MCLK) disable iff (RST)
        (PREADY && PWRITE && idx == acrc_pkg::IDX_CHANNEL_POWER_ENABLE[5:0]) |=> pwr_reg_ff == $past(PWDATA[7:0]))
        else $error("channel register write lost");

    // a read of the channel register returns the stored byte
    pwr_read_a: assert property (@(posedge MCLK) disable iff (RST)
        (PREADY && !PWRITE && idx == acrc_pkg::IDX_CHANNEL_POWER_ENABLE[5:0]) |-> PRDATA == {24'h0, pwr_reg_ff})
        else $error("channel register readback");

    // write to the modulator word lands in storage
    mod_write_a: assert property (@(posedge MCLK) disable iff (RST)
        (PREADY && PWRITE && idx == acrc_pkg::IDX_MOD_CLOCK_AND_RATE[5:0]) |=> mod_reg_ff == $past(PWDATA[7:0]))
        else $error("modulator register write lost");

    // write to the internal clock word lands in storage
    internal_clock_write_a: assert property (@(posedge MCLK) disable iff (RST)
        (PREADY && PWRITE && idx == acrc_pkg::IDX_INTERNAL_CLOCK_CFG[5:0]) |=> internal_clock_reg_ff == $past(PWDATA[7:0]))
        else $error("internal clock register write lost");

endmodule

// *** bench/acrc_host_model.sv ***
`timescale 1ns/10ps
// host side: an apb master that writes and reads the configuration words
module acrc_host_model (
    input wire logic MCLK,
    input wire logic PREADY,
    output logic PSEL,
    output logic PENABLE,
    output logic PWRITE,
    output logic [7:0] PADDR,
    output logic [31:0] PWDATA
);
    //////////////////////////////////////////////////////////////////////
    // idle bus from time zero
    initial begin
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
    end

    //////////////////////////////////////////////////////////////////////
    // one transfer: setup, access held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        d = data;
        // reserved bit of the modulator word is always written as zero
        if (addr == {acrc_pkg::IDX_MOD_CLOCK_AND_RATE[5:0], 2'b00}) d[4] = 1'b0;
        // power word: only all-off or all-on, upper bits zero
        if (addr == {acrc_pkg::IDX_CHANNEL_POWER_ENABLE[5:0], 2'b00}) begin
            d = (d[3:0] == acrc_pkg::PWR_ALL_UP) ? 32'h0f : 32'h0;
        end
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= addr;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        // hold the access phase until pready is sampled high at a rising edge, then release
        @(posedge MCLK);
        while (PREADY !== 1'b1) @(posedge MCLK);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
endmodule

// *** bench/tb_acrc_top.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h seen %h", nm, e, s); end end
module tb_acrc_top;
    typedef struct {int kind; logic [32:0] val; int t_from;} acrc_exp_type;
    logic MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, INTERNAL_CLOCK, MOD_CLOCK, DATA_READY;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [3:0] CHANNEL_POWER;
    acrc_exp_type q[$]; // expectations, oldest first
    string names[6] = '{"prdata", "internal_clock_period", "mod_period", "drdy_period", "ch_power", "mod_hold"};
    int ratio[16] = '{4096, 2048, 1024, 800, 768, 512, 400, 384, 256, 200, 192, 128, 96, 64, 48, 32};
    int n_errors = 0, n_compared = 0, cyc = 0, seed = 572;
    int last_i = 0, last_m = 0, last_d = 0; // last rising point of each output
    logic iq = 1'b0, mq = 1'b0;
    logic [3:0] pq = 4'h0;

    acrc_top i_dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .INTERNAL_CLOCK(INTERNAL_CLOCK), .MOD_CLOCK(MOD_CLOCK), .DATA_READY(DATA_READY),
        .CHANNEL_POWER(CHANNEL_POWER));
    acrc_host_model i_host (.MCLK(MCLK), .PREADY(PREADY), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA));

    //////////////////////////////////////////////////////////////////////
    // clock, cycle count
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    always @(posedge MCLK) cyc <= cyc + 1;

    //////////////////////////////////////////////////////////////////////
    // watcher: the oldest note is compared when its kind of result shows
    always @(negedge MCLK) begin
        logic ev;
        logic [32:0] seen;
        ev = 1'b0;
        seen = 33'h0;
        if (q.size() > 0) begin
            case (q[0].kind)
                0: begin // read completes this cycle
                    ev = (PSEL === 1'b1) && (PENABLE === 1'b1) && (PREADY === 1'b1) && (PWRITE === 1'b0);
                    seen = {PSLVERR, PRDATA};
                end
                1: begin
                    ev = INTERNAL_CLOCK === 1'b1 && !iq && last_i >= q[0].t_from;
                    seen = 33'(cyc - last_i);
                end
                2: begin
                    ev = MOD_CLOCK === 1'b1 && !mq && last_m >= q[0].t_from;
                    seen = 33'(cyc - last_m);
                end
                3: begin
                    ev = DATA_READY === 1'b1 && last_d >= q[0].t_from;
                    seen = 33'(cyc - last_d);
                end
                5: begin // modulator level once the settle time has passed
                    ev = cyc >= q[0].t_from;
                    seen = {32'h0, MOD_CLOCK};
                end
                default: begin
                    ev = CHANNEL_POWER !== pq;
                    seen = {29'h0, CHANNEL_POWER};
                end
            endcase
            if (ev) begin
                `CHK(names[q[0].kind], q[0].val, seen)
                void'(q.pop_front());
            end
        end
        // remember rising points after the comparison used the previous one
        if (INTERNAL_CLOCK === 1'b1 && !iq) last_i = cyc;
        if (MOD_CLOCK === 1'b1 && !mq) last_m = cyc;
        if (DATA_READY === 1'b1) last_d = cyc;
        iq = INTERNAL_CLOCK;
        mq = MOD_CLOCK;
        pq = CHANNEL_POWER;
    end

    //////////////////////////////////////////////////////////////////////
    // helpers: note an expectation, then drive
    task automatic note(input int k, input logic [32:0] v, input int from);
        acrc_exp_type e;
        e.kind = k;
        e.val = v;
        e.t_from = from;
        q.push_back(e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        note(0, e, 0);
        i_host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic drain();
        while (q.size() > 0) @(posedge MCLK);
    endtask
    task automatic summarize();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        #2500000;
        n_errors++;
        summarize();
    end

    //////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        RST = 1'b1;
        repeat (3) @(posedge MCLK);
        RST <= 1'b0;
        // reset values of all four words
        rd(8'h34, 33'h08);
        rd(8'h38, 33'h86);
        rd(8'h3c, 33'h00);
        rd(8'h40, 33'h00);
        // reset clocking: internal 8, modulator 64 system cycles
        note(1, 33'd8, cyc + 40);
        note(2, 33'd64, cyc + 300);
        drain();
        // unmapped word: random write ignored, read refused
        i_host.xfer(1'b1, 8'h44, $random(seed));
        rd(8'h44, {1'b1, 32'h0});
        rd(8'h40, 33'h00);
        // fastest internal clock, then modulator divider codes 1 to 7
        i_host.xfer(1'b1, 8'h34, 32'h02);
        note(1, 33'd2, cyc + 40);
        for (int k = 1; k < 8; k++) begin
            i_host.xfer(1'b1, 8'h38, {24'h0, 3'(k), 5'h0f});
            note(2, 33'(4 * k), cyc + 80);
            drain();
        end
        // power all channels, then every ratio from shortest to longest
        i_host.xfer(1'b1, 8'h38, 32'h2f);
        i_host.xfer(1'b1, 8'h3c, 32'h0f);
        note(4, 33'h0f, 0);
        for (int c = 15; c >= 0; c--) begin
            i_host.xfer(1'b1, 8'h38, {24'h0, 4'h2, 4'(c)});
            // skip a word end decided before the new code landed
            note(3, 33'(4 * ratio[c]), cyc + 2);
            drain();
        end
        rd(8'h38, 33'h20);
        rd(8'h3c, 33'h0f);
        // power down again
        i_host.xfer(1'b1, 8'h3c, 32'h00);
        note(4, 33'h00, 0);
        drain();
        // reserved modulator code: the modulator clock parks low
        i_host.xfer(1'b1, 8'h38, 32'h06);
        note(5, 33'h0, cyc + 100);
        drain();
        summarize();
    end
endmodule
